// [bench/host_link_model.sv]
// host on the command link: makes the link clock and issues commands
`timescale 1ns/1ps
`default_nettype none
module host_link_model
(
  // link clock and request
  output logic        o_link_clk,
  output logic        o_cmd_valid,
  output logic [7:0]  o_cmd_code,
  // answer
  input  wire logic   i_cmd_ready,
  input  wire logic   i_rsp_valid,
  input  wire logic [15:0] i_rsp_data
);
  logic run;
  // ==========
  // clock runs through reset, then only while a command is open
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_code  = 8'hA5;
    run         = 1'b1;
  end
  initial
  begin
    o_link_clk = 1'b0;
    #7;
    forever #15 if (run) o_link_clk = ~o_link_clk;
  end
  // ==========
  // one command, held until taken, answer caught on its pulse
  task automatic command(input logic [7:0] code, output logic [15:0] data);
    int n;
    n = 0;
    data = 16'hXXXX;
    run = 1'b1;
    @(posedge o_link_clk);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd_code  = code;
    @(posedge o_link_clk);
    while (!i_cmd_ready && n < 50)
    begin
      @(posedge o_link_clk);
      n++;
    end
    #1;
    o_cmd_valid = 1'b0;
    // released byte shows the inverse so a stale code never matches
    o_cmd_code  = ~code;
    n = 0;
    @(posedge o_link_clk);
    while (!i_rsp_valid && n < 60)
    begin
      @(posedge o_link_clk);
      n++;
    end
    if (i_rsp_valid)
      data = i_rsp_data;
    repeat (3) @(posedge o_link_clk);
    run = 1'b0;
  endtask
endmodule // host_link_model
`default_nettype wire

// [bench/result_fifo_status_flags_test.sv]
// self-checking bench for the result queue and its flag registers
`timescale 1ns/1ps
`default_nettype none
`include "result_fifo_params.svh"
module result_fifo_status_flags_test;
  logic        i_sys_clk;
  logic        i_rst_b;
  logic        link_clk;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [7:0]  cmd_code;
  logic [15:0] rsp_data;
  logic [15:0] got;
  logic        adc_valid;
  logic        lut_mode;
  logic        lut_valid;
  logic        lut_cfg;
  logic        lut_ready;
  logic [3:0]  adc_tag;
  logic [3:0]  lut_tag;
  logic [3:0]  busy_v;
  logic [11:0] adc_value;
  logic [11:0] alarm_v;
  logic [12:0] lut_value;
  logic [2:0]  ev_v;
  int          errors;
  int          n_checks;

  initial i_sys_clk = 1'b0;
  always #50 i_sys_clk = ~i_sys_clk;

  result_fifo_status_flags result_fifo_status_flags_i
  (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_link_clk(link_clk),
    .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code),
    .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid),
    .o_rsp_data(rsp_data), .i_adc_valid(adc_valid),
    .i_adc_tag(adc_tag), .i_adc_value(adc_value),
    .i_lut_mode(lut_mode), .i_lut_valid(lut_valid),
    .i_lut_cfg(lut_cfg), .i_lut_tag(lut_tag), .i_lut_value(lut_value),
    .o_lut_ready(lut_ready), .i_queue_clear_request(ev_v[2]),
    .i_soft_clear(ev_v[1]), .i_restart_event(ev_v[0]),
    .i_core_misc_active(busy_v[3]), .i_gain_cal_active(busy_v[2]),
    .i_converter_active(busy_v[1]),
    .i_gate_code_calc_active(busy_v[0]),
    .i_ch2_gate_over(alarm_v[11]), .i_ch2_gate_under(alarm_v[10]),
    .i_ch2_sense_over(alarm_v[9]), .i_ch2_sense_under(alarm_v[8]),
    .i_ch2_temp_over(alarm_v[7]), .i_ch2_temp_under(alarm_v[6]),
    .i_ch1_gate_over(alarm_v[5]), .i_ch1_gate_under(alarm_v[4]),
    .i_ch1_sense_over(alarm_v[3]), .i_ch1_sense_under(alarm_v[2]),
    .i_ch1_temp_over(alarm_v[1]), .i_ch1_temp_under(alarm_v[0])
  );

  host_link_model host_link_model_i
  (
    .o_link_clk(link_clk), .o_cmd_valid(cmd_valid),
    .o_cmd_code(cmd_code), .i_cmd_ready(cmd_ready),
    .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data)
  );

  // ==========
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    host_link_model_i.command(code, got);
    check(got, exp);
  endtask
  task automatic set_ev(input logic [11:0] al, input logic [2:0] ev);
    @(negedge i_sys_clk);
    alarm_v = al;
    ev_v    = ev;
    @(negedge i_sys_clk);
    alarm_v = 12'h000;
    ev_v    = 3'h0;
  endtask
  function automatic logic [15:0] adcw(input int i);
    return {4'(i % 11), 12'h5A0 + 12'(i)};
  endfunction
  task automatic adc_push(input int i);
    logic [15:0] w;
    w = adcw(i);
    @(negedge i_sys_clk);
    adc_valid = 1'b1;
    adc_tag   = w[15:12];
    adc_value = w[11:0];
    @(negedge i_sys_clk);
    adc_valid = 1'b0;
  endtask
  // word 0 is a configuration word; bit 12 set elsewhere must not leak
  function automatic logic [15:0] lutw(input int i);
    return (i == 0) ? 16'hDABC : {4'hD, 12'(i)};
  endfunction
  task automatic lut_push(input int i);
    @(negedge i_sys_clk);
    lut_valid = 1'b1;
    lut_cfg   = (i == 0);
    lut_tag   = (i == 0) ? 4'hC : 4'hD;
    lut_value = (i == 0) ? 13'h1ABC : (13'h1000 | 13'(i));
    @(negedge i_sys_clk);
    lut_valid = 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========
  // tests take well under 200 us; a hang ends here
  initial
  begin
    #3000000;
    errors++;
    give_verdict;
  end

  // ==========
  // main sequence
  initial
  begin
    errors = 0; n_checks = 0; i_rst_b = 1'b0;
    adc_valid = 1'b0; adc_tag = 4'h0; adc_value = 12'h000;
    lut_mode = 1'b0; lut_valid = 1'b0; lut_cfg = 1'b0;
    lut_tag = 4'h0; lut_value = 13'h0000;
    busy_v = 4'h0; alarm_v = 12'h000; ev_v = 3'h0;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_b = 1'b1;
    rd(`CMD_FLAG_RD, 16'h0002);
    rd(`CMD_ALARM_RD, 16'h0000);
    rd(`CMD_FIFO_RD, 16'hF002);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge i_sys_clk);
      busy_v = 4'(1 << i);
      rd(`CMD_FLAG_RD, 16'h2 | 16'(4 << i));
    end
    @(negedge i_sys_clk);
    busy_v = 4'h0;
    set_ev(12'h000, 3'b001);
    rd(`CMD_FLAG_RD, 16'h0042);
    rd(`CMD_FLAG_RD, 16'h0002);
    for (int i = 0; i < 12; i++)
    begin
      set_ev(12'h800 >> i, 3'b000);
      rd(`CMD_ALARM_RD, 16'h0800 >> i);
      rd(`CMD_ALARM_RD, 16'h0000);
    end
    set_ev(12'hFFF, 3'b000);
    set_ev(12'h000, 3'b010);
    rd(`CMD_ALARM_RD, 16'h0000);
    set_ev(12'h801, 3'b010);
    rd(`CMD_ALARM_RD, 16'h0801);
    for (int i = 0; i < 3; i++) adc_push(i);
    rd(`CMD_FLAG_RD, 16'h0000);
    for (int i = 0; i < 3; i++) rd(`CMD_FIFO_RD, adcw(i));
    rd(`CMD_FIFO_RD, 16'hF002);
    // one push too many drops the oldest and sets a sticky overflow
    for (int i = 0; i < 16; i++) adc_push(i);
    for (int i = 1; i < 16; i++) rd(`CMD_FIFO_RD, adcw(i));
    rd(`CMD_FLAG_RD, 16'h0003);
    rd(`CMD_FLAG_RD, 16'h0002);
    for (int i = 0; i < 17; i++) adc_push(i);
    // a push on a full queue at the read edge spoils that one answer
    @(negedge i_sys_clk);
    adc_valid = 1'b1;
    host_link_model_i.command(`CMD_FIFO_RD, got);
    @(negedge i_sys_clk);
    adc_valid = 1'b0;
    check({12'h000, got[15:12]}, {12'h000, `TAG_CORRUPT});
    rd(`CMD_FLAG_RD, 16'h0001);
    set_ev(12'h000, 3'b100);
    rd(`CMD_FLAG_RD, 16'h0002);
    rd(`CMD_FIFO_RD, 16'hF002);
    // table words enter only while the queue is not full
    @(negedge i_sys_clk);
    lut_mode = 1'b1;
    for (int i = 0; i < 16; i++) lut_push(i);
    check({15'h0, lut_ready}, 16'h0000);
    rd(`CMD_FLAG_RD, 16'h0001);
    rd(`CMD_FIFO_RD, lutw(0));
    check({15'h0, lut_ready}, 16'h0001);
    rd(`CMD_FLAG_RD, 16'h0000);
    lut_push(16);
    // each table word carries its own index in the low bits, so each read checks one word in order
    for (int i = 1; i < 17; i++) rd(`CMD_FIFO_RD, lutw(i));
    rd(`CMD_FIFO_RD, 16'hF002);
    give_verdict;
  end
endmodule // result_fifo_status_flags_test
`default_nettype wire

// [rtl/link_cmd_port.sv]
// command handshake between the link clock and the system clock
`timescale 1ns/1ps
`default_nettype none
module link_cmd_port
(
  // clocks and reset
  input  wire logic   i_link_clk,
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst_b,
  // link side
  input  wire logic   i_cmd_valid,
  input  wire logic [7:0] i_cmd_code,
  output logic        o_cmd_ready,
  output logic        o_rsp_valid,
  output logic [15:0] o_rsp_data,
  // system side
  output logic        o_sys_cmd,
  output logic [7:0]  o_sys_code,
  input  wire logic [15:0] i_sys_rsp,
  input  wire logic   i_sys_done
);
  logic       pend_q, req_q, ack_q;
  logic       ack1_q, ack2_q, ack3_q;
  logic       req1_q, req2_q, req3_q;
  logic [7:0] code_q;
  wire logic  take = i_cmd_valid & ~pend_q;
  wire logic  back = ack2_q ^ ack3_q;
  assign o_cmd_ready = ~pend_q;
  assign o_sys_cmd   = req2_q ^ req3_q;
  // code is held steady while the request is pending
  assign o_sys_code  = code_q;
  always_ff @(posedge i_link_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      {pend_q, req_q, ack1_q, ack2_q, ack3_q} <= 5'h00;
      code_q      <= 8'h00;
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= 16'h0000;
    end
    else
    begin
      {ack3_q, ack2_q, ack1_q} <= {ack2_q, ack1_q, ack_q};
      pend_q      <= take | (pend_q & ~back);
      req_q       <= req_q ^ take;
      code_q      <= take ? i_cmd_code : code_q;
      o_rsp_valid <= back;
      o_rsp_data  <= back ? i_sys_rsp : o_rsp_data;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      {req3_q, req2_q, req1_q, ack_q} <= 4'h0;
    else
    begin
      {req3_q, req2_q, req1_q} <= {req2_q, req1_q, req_q};
      ack_q <= ack_q ^ i_sys_done;
    end
  end
endmodule // link_cmd_port
`default_nettype wire

// [rtl/queue_if.sv]
// carrier between queue control and queue storage
`timescale 1ns/1ps
`default_nettype none
interface queue_if;
  import result_fifo_pkg::*;
  logic   push;
  logic   drop;
  logic   pop;
  logic   clear;
  word_t  push_word;
  word_t  head;
  count_t count;
  modport ctrl (output push, drop, pop, clear, push_word,
                input head, count);
  modport store (input push, drop, pop, clear, push_word,
                 output head, count);
endinterface
`default_nettype wire

// [rtl/result_fifo_params.svh]
// constants for the result queue and its flag registers
`ifndef RESULT_FIFO_PARAMS_SVH
`define RESULT_FIFO_PARAMS_SVH
// command codes
`define CMD_FIFO_RD   8'h80
`define CMD_FLAG_RD   8'hF6
`define CMD_ALARM_RD  8'hF8
// word layout
`define TAG_HI        15
`define TAG_LO        12
`define TAG_EMPTY     4'hF
`define TAG_CORRUPT   4'hE
// queue depths per data kind
`define DEPTH_ADC     5'd15
`define DEPTH_LUT     5'd16
// busy_status_flags bit positions
`define FLG_RESTART   6
`define FLG_MISC      5
`define FLG_GAINCAL   4
`define FLG_CONV      3
`define FLG_GATECALC  2
`define FLG_EMPTY     1
`define FLG_OVR       0
// reset values
`define ALARM_RST     12'h000
`define WORD_RST      16'h0000
`endif

// [rtl/result_fifo_pkg.sv]
// types shared by the result queue modules
package result_fifo_pkg;
  typedef logic [15:0] word_t;
  typedef logic [4:0]  count_t;
  typedef enum logic [3:0]
  {
    CK_FIFO  = 4'b0001,
    CK_FLAG  = 4'b0010,
    CK_ALARM = 4'b0100,
    CK_OTHER = 4'b1000
  } cmd_kind_e;
endpackage

// [rtl/result_fifo_status_flags.sv]
// result queue with busy/status and alarm flag registers
//
// Function
// - fifo read command 80h returns oldest entry and removes it
// - entry holds 4-bit tag on top, 12-bit result below
// - table configuration words: 3-bit tag, value in bits 12..0
// - status command F6h returns flags, bits 15..7 undefined
// - bit 6 set by reboot event, cleared by status read or reset
// - bit 5 shows miscellaneous core activity
// - bit 4 shows gain calibration activity
// - bit 3 shows converter, alarm check or queue loading activity
// - bit 2 shows table lookup or gate code calculation
// - bit 1 high while queue empty, high again after clear
// - adc mode: bit 0 sticky overflow, cleared by read or clear
// - table mode: bit 0 shows instantaneous full
// - alarm command F8h returns flags, read or clear zeroes them
// - channel 2 alarm flags in bits 11..6
// - channel 1 alarm flags in bits 5..0
// - queue holds 15 adc entries or 16 table entries
// - adc overflow discards oldest, keeps 15 newest
// - table words never overflow the queue
// - read of empty queue returns tag 1111 plus flag bits
// - overflowing adc push during read tags that item 1110
// - table copying pauses while queue full, resumes after read
`timescale 1ns/1ps
`default_nettype none
`include "result_fifo_params.svh"
module result_fifo_status_flags
(
  // system clock and reset
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst_b,
  // serial link command port
  input  wire logic   i_link_clk,
  input  wire logic   i_cmd_valid,
  input  wire logic [7:0] i_cmd_code,
  output logic        o_cmd_ready,
  output logic        o_rsp_valid,
  output result_fifo_pkg::word_t o_rsp_data,
  // adc results
  input  wire logic   i_adc_valid,
  input  wire logic [3:0]  i_adc_tag,
  input  wire logic [11:0] i_adc_value,
  // table words
  input  wire logic   i_lut_mode,
  input  wire logic   i_lut_valid,
  input  wire logic   i_lut_cfg,
  input  wire logic [3:0]  i_lut_tag,
  input  wire logic [12:0] i_lut_value,
  output logic        o_lut_ready,
  // control events
  input  wire logic   i_queue_clear_request,
  input  wire logic   i_soft_clear,
  input  wire logic   i_restart_event,
  // busy sources
  input  wire logic   i_core_misc_active,
  input  wire logic   i_gain_cal_active,
  input  wire logic   i_converter_active,
  input  wire logic   i_gate_code_calc_active,
  // alarm events, channel 2
  input  wire logic   i_ch2_gate_over,
  input  wire logic   i_ch2_gate_under,
  input  wire logic   i_ch2_sense_over,
  input  wire logic   i_ch2_sense_under,
  input  wire logic   i_ch2_temp_over,
  input  wire logic   i_ch2_temp_under,
  // alarm events, channel 1
  input  wire logic   i_ch1_gate_over,
  input  wire logic   i_ch1_gate_under,
  input  wire logic   i_ch1_sense_over,
  input  wire logic   i_ch1_sense_under,
  input  wire logic   i_ch1_temp_over,
  input  wire logic   i_ch1_temp_under
);
  import result_fifo_pkg::*;

  // ==========================================================
  // link crossing
  logic       sys_cmd;
  logic [7:0] sys_code;
  word_t      rsp_q;
  logic       done_q;

  link_cmd_port u_link
  (
    .i_link_clk  (i_link_clk),
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_cmd_valid (i_cmd_valid),
    .i_cmd_code  (i_cmd_code),
    .o_cmd_ready (o_cmd_ready),
    .o_rsp_valid (o_rsp_valid),
    .o_rsp_data  (o_rsp_data),
    .o_sys_cmd   (sys_cmd),
    .o_sys_code  (sys_code),
    .i_sys_rsp   (rsp_q),
    .i_sys_done  (done_q)
  );

  // ==========================================================
  // command decode
  cmd_kind_e  kind;
  assign kind = (sys_code == `CMD_FIFO_RD)  ? CK_FIFO  :
                (sys_code == `CMD_FLAG_RD)  ? CK_FLAG  :
                (sys_code == `CMD_ALARM_RD) ? CK_ALARM : CK_OTHER;
  wire logic fifo_rd  = sys_cmd & (kind == CK_FIFO);
  wire logic flag_rd  = sys_cmd & (kind == CK_FLAG);
  wire logic alarm_rd = sys_cmd & (kind == CK_ALARM);

  // ==========================================================
  // queue
  queue_if qi ();

  result_queue u_queue
  (
    .i_sys_clk (i_sys_clk),
    .i_rst_b   (i_rst_b),
    .q         (qi.store)
  );

  wire logic q_empty  = (qi.count == 5'h00);
  wire logic full_adc = (qi.count == `DEPTH_ADC);
  wire logic full_lut = (qi.count == `DEPTH_LUT);
  wire logic pop      = fifo_rd & ~q_empty;

  // table words wait while the queue is full; a read frees a slot
  assign o_lut_ready  = i_lut_mode & ~full_lut;
  wire logic lut_push = i_lut_valid & o_lut_ready;
  wire logic adc_push = i_adc_valid & ~i_lut_mode;
  wire logic adc_ovf  = adc_push & full_adc & ~i_queue_clear_request;
  wire logic drop     = adc_ovf & ~pop;
  wire logic corrupt  = adc_ovf & pop;

  wire word_t adc_word = {i_adc_tag, i_adc_value};
  wire word_t lut_word = i_lut_cfg ?
                         {i_lut_tag[3:1], i_lut_value} :
                         {i_lut_tag, i_lut_value[11:0]};

  assign qi.push      = adc_push | lut_push;
  assign qi.drop      = drop;
  assign qi.pop       = pop;
  assign qi.clear     = i_queue_clear_request;
  assign qi.push_word = i_lut_mode ? lut_word : adc_word;

  // ==========================================================
  // busy/status flags
  logic restart_q;
  logic ovr_q;

  // reboot events win over the read that would clear them
  wire logic restart_d = i_restart_event |
                         (restart_q & ~flag_rd);
  // overflow is sticky in adc mode; draining does not clear it
  wire logic ovr_d = drop |
                     (ovr_q & ~flag_rd & ~i_queue_clear_request);
  wire logic ovr_bit = i_lut_mode ? full_lut : ovr_q;

  wire logic [6:0] flags;
  assign flags[`FLG_RESTART]  = restart_q;
  assign flags[`FLG_MISC]     = i_core_misc_active;
  assign flags[`FLG_GAINCAL]  = i_gain_cal_active;
  assign flags[`FLG_CONV]     = i_converter_active;
  assign flags[`FLG_GATECALC] = i_gate_code_calc_active;
  assign flags[`FLG_EMPTY]    = q_empty;
  assign flags[`FLG_OVR]      = ovr_bit;

  // undefined upper bits read as zero
  wire word_t flag_word = {9'h000, flags};

  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      restart_q <= 1'b0;
      ovr_q     <= 1'b0;
    end
    else
    begin
      restart_q <= restart_d;
      ovr_q     <= ovr_d;
    end
  end

  // ==========================================================
  // alarm flags
  logic [11:0] alarm_q;
  wire logic [11:0] alarm_set =
  {
    i_ch2_gate_over,  i_ch2_gate_under,
    i_ch2_sense_over, i_ch2_sense_under,
    i_ch2_temp_over,  i_ch2_temp_under,
    i_ch1_gate_over,  i_ch1_gate_under,
    i_ch1_sense_over, i_ch1_sense_under,
    i_ch1_temp_over,  i_ch1_temp_under
  };
  wire logic alarm_clr = alarm_rd | i_soft_clear;

  // constant reset pattern, so the async branch loads no logic
  localparam logic [11:0] alarm_init = `ALARM_RST;
  genvar b;
  generate
    for (b = 0; b < 12; b = b + 1)
    begin : g_alarm
      always_ff @(posedge i_sys_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
          alarm_q[b] <= alarm_init[b];
        else
          alarm_q[b] <= alarm_set[b] |
                        (alarm_q[b] & ~alarm_clr);
      end
    end
  endgenerate

  // ==========================================================
  // answer word
  // an empty read carries the flags so the host can tell it apart
  wire word_t empty_word = {`TAG_EMPTY, 5'h00, flags};
  wire word_t pop_word   = corrupt ?
                           {`TAG_CORRUPT, qi.head[11:0]} :
                           qi.head;
  word_t rsp_d;
  always_comb
  begin
    case (kind)
      CK_FIFO:  rsp_d = q_empty ? empty_word : pop_word;
      CK_FLAG:  rsp_d = flag_word;
      CK_ALARM: rsp_d = {4'h0, alarm_q};
      default:  rsp_d = `WORD_RST;
    endcase
  end

  // answer and completion move on the same edge, so the word is
  // steady before the link side sees the acknowledge
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rsp_q  <= `WORD_RST;
      done_q <= 1'b0;
    end
    else
    begin
      rsp_q  <= sys_cmd ? rsp_d : rsp_q;
      done_q <= sys_cmd;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  empty_read_tag_a: assert property (
    fifo_rd && q_empty |=> rsp_q[15:12] == `TAG_EMPTY
      && rsp_q[6:0] == $past(flags))
    else $error("empty read lacks tag 1111");

  corrupt_tag_a: assert property (
    fifo_rd && corrupt |=> rsp_q[15:12] == `TAG_CORRUPT)
    else $error("colliding read not tagged 1110");

  restart_clear_a: assert property (
    flag_rd && !i_restart_event |=> !restart_q)
    else $error("reboot bit survived status read");

  restart_set_a: assert property (
    i_restart_event |=> restart_q)
    else $error("reboot event lost");

  alarm_keep_a: assert property (
    alarm_clr |=> alarm_q == $past(alarm_set))
    else $error("alarm lost in clear cycle");

  alarm_clear_a: assert property (
    alarm_rd && alarm_set == 12'h000 |=> alarm_q == 12'h000
      && rsp_q[11:0] == $past(alarm_q))
    else $error("alarm read did not clear");

  ovr_sticky_a: assert property (
    ovr_q && !flag_rd && !i_queue_clear_request |=> ovr_q [*1])
    else $error("overflow bit dropped");

  lut_full_a: assert property (
    i_lut_mode |-> flags[`FLG_OVR] == full_lut)
    else $error("table mode overflow bit wrong");

  lut_no_ovf_a: assert property (
    i_lut_mode && full_lut && !pop && !i_queue_clear_request
      |=> qi.count == `DEPTH_LUT)
    else $error("table queue overflowed");

  adc_depth_a: assert property (
    !i_lut_mode && drop |=> qi.count == `DEPTH_ADC && ovr_q)
    else $error("adc overflow depth wrong");

  clear_empty_a: assert property (
    i_queue_clear_request && !qi.push |=> q_empty && !ovr_q)
    else $error("clear did not empty queue");

  // ==========================================================
  // answer and depth checks
  push_not_empty_a: assert property (
    qi.push |=> !q_empty)
    else $error("queue empty after a push");

  pop_head_a: assert property (
    fifo_rd && !q_empty && !corrupt |=> rsp_q == $past(qi.head))
    else $error("fifo read did not return oldest entry");

  flag_word_a: assert property (
    flag_rd |=> rsp_q == {9'h000, $past(flags)})
    else $error("status read not taken before clear");

  ovr_clear_a: assert property (
    flag_rd && !drop |=> !ovr_q)
    else $error("status read left overflow set");

  lut_resume_a: assert property (
    i_lut_mode && full_lut && pop && !i_queue_clear_request
      |=> qi.count == 5'h0F)
    else $error("read did not free a table slot");

  adc_depth_max_a: assert property (
    !i_lut_mode |-> qi.count <= `DEPTH_ADC)
    else $error("adc queue deeper than fifteen");

  lut_depth_max_a: assert property (
    qi.count <= `DEPTH_LUT)
    else $error("queue deeper than sixteen");

  // the answer pulse lives on the link clock, not the default one
  rsp_pulse_a: assert property (
    @(posedge i_link_clk) disable iff (!i_rst_b)
    o_rsp_valid |=> !o_rsp_valid)
    else $error("answer pulse longer than one link cycle");

endmodule // result_fifo_status_flags
`default_nettype wire

// [rtl/result_queue.sv]
// sixteen-entry queue storage with overwrite of the oldest entry
`timescale 1ns/1ps
`default_nettype none
module result_queue
(
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_b,
  // control side
  queue_if.store    q
);
  import result_fifo_pkg::*;
  word_t       mem [0:15];
  logic [3:0]  rd_q;
  logic [3:0]  wr_q;
  count_t      cnt_q;
  wire logic   adv = q.pop | (q.push & q.drop);
  wire logic [3:0] waddr = q.clear ? 4'h0 : wr_q;
  wire logic [3:0] wr_d = waddr + {3'h0, q.push};
  wire logic [3:0] rd_d = q.clear ? 4'h0 : rd_q + {3'h0, adv};
  wire count_t inc = {4'h0, q.push & ~q.drop};
  wire count_t dec = {4'h0, q.pop};
  // a push in the clearing cycle lands in the freshly emptied queue
  wire count_t cnt_d = q.clear ? inc : cnt_q + inc - dec;
  assign q.head  = mem[rd_q];
  assign q.count = cnt_q;
  always_ff @(posedge i_sys_clk)
  begin
    if (q.push)
      mem[waddr] <= q.push_word;
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rd_q  <= 4'h0;
      wr_q  <= 4'h0;
      cnt_q <= 5'h00;
    end
    else
    begin
      rd_q  <= rd_d;
      wr_q  <= wr_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // result_queue
`default_nettype wire
